// ### pdc_clkdiv.sv
// Clock-enable dividers for the main oscillator and the watch clock
`include "pdc_params.svh"

module pdc_clkdiv (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    pdc_div_if.div    dif
);

    logic [5:0] main_cnt_ff;
    logic [2:0] sub_cnt_ff;
    logic       main_tick_ff;
    logic       sub_tick_ff;

    function automatic logic [5:0] main_tc(input logic [2:0] code);
        case (code)
            3'h4:    main_tc = `PDC_TC_DIV8;
            3'h5:    main_tc = `PDC_TC_DIV16;
            3'h6:    main_tc = `PDC_TC_DIV32;
            3'h7:    main_tc = `PDC_TC_DIV64;
            default: main_tc = `PDC_TC_DIV1;
        endcase
    endfunction : main_tc

    function automatic logic [2:0] sub_tc(input logic [1:0] code);
        case (code)
            2'h0:    sub_tc = `PDC_TC_SUB8;
            2'h1:    sub_tc = `PDC_TC_SUB4;
            default: sub_tc = `PDC_TC_SUB2;
        endcase
    endfunction : sub_tc

    // Main rate: 0xx undivided, 100..111 by 8/16/32/64
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            main_cnt_ff  <= 6'h00;
            main_tick_ff <= 1'b0;
        end else if (ce) begin
            if (!dif.run_main) begin
                main_cnt_ff  <= 6'h00;
                main_tick_ff <= 1'b0;
            end else if (main_cnt_ff >= main_tc(dif.act_code)) begin
                main_cnt_ff  <= 6'h00;
                main_tick_ff <= 1'b1;
            end else begin
                main_cnt_ff  <= main_cnt_ff + 6'h01;
                main_tick_ff <= 1'b0;
            end
        end
    end

    // Sub rate counts watch-clock edges: 00 by 8, 01 by 4, 1x by 2
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sub_cnt_ff  <= 3'h0;
            sub_tick_ff <= 1'b0;
        end else if (ce) begin
            if (!dif.run_sub) begin
                sub_cnt_ff  <= 3'h0;
                sub_tick_ff <= 1'b0;
            end else if (!dif.watch_tick) begin
                sub_tick_ff <= 1'b0;
            end else if (sub_cnt_ff >= sub_tc(dif.sub_code)) begin
                sub_cnt_ff  <= 3'h0;
                sub_tick_ff <= 1'b1;
            end else begin
                sub_cnt_ff  <= sub_cnt_ff + 3'h1;
                sub_tick_ff <= 1'b0;
            end
        end
    end

    assign dif.main_tick = main_tick_ff;
    assign dif.sub_tick  = sub_tick_ff;

    main_undiv_a: assert property (@(posedge clk) disable iff (rst)
        (ce && dif.run_main && !dif.act_code[2] && $past(dif.run_main) && $past(ce))
        |=> main_tick_ff)
        else $error("Undivided main rate missed a tick");

    main_div64_a: assert property (@(posedge clk) disable iff (rst)
        (ce && main_tick_ff && dif.act_code == 3'h7)
        |=> (!main_tick_ff || dif.act_code != 3'h7) [*8])
        else $error("Divide-by-64 tick came too early");

    sub_div2_a: assert property (@(posedge clk) disable iff (rst)
        (ce && dif.run_sub && dif.watch_tick && dif.sub_code[1] && sub_cnt_ff == 3'h1)
        |=> sub_tick_ff)
        else $error("Watch divide-by-2 tick missing");

endmodule : pdc_clkdiv

// ### pdc_div_if.sv
// Carrier between the control core and the clock-enable dividers
interface pdc_div_if;
    logic [2:0] act_code;
    logic [1:0] sub_code;
    logic       run_main;
    logic       run_sub;
    logic       watch_tick;
    logic       main_tick;
    logic       sub_tick;

    modport core (
        output act_code,
        output sub_code,
        output run_main,
        output run_sub,
        output watch_tick,
        input  main_tick,
        input  sub_tick
    );

    modport div (
        input  act_code,
        input  sub_code,
        input  run_main,
        input  run_sub,
        input  watch_tick,
        output main_tick,
        output sub_tick
    );
endinterface : pdc_div_if

// ### pdc_params.svh
// Constants of the power-down and clock-divider control block
`ifndef PDC_PARAMS_SVH
`define PDC_PARAMS_SVH

`define PDC_ADDR_W          12
`define PDC_OFS_CTRL_B      12'h000
`define PDC_OFS_MSTBY_A     12'h004
`define PDC_OFS_CTRL_A      12'h008
`define PDC_OFS_STATUS      12'h00c

`define PDC_RST_CTRL_B      8'h00
`define PDC_RST_MSTBY_A     8'h00
`define PDC_RST_CTRL_A      8'h00

`define PDC_BIT_SUB_SLEEP   7
`define PDC_BIT_LOW_SPEED   6
`define PDC_BIT_DIRECT      5
`define PDC_ACT_DIV_HI      4
`define PDC_ACT_DIV_LO      2
`define PDC_SUB_DIV_HI      1
`define PDC_SUB_DIV_LO      0
`define PDC_BIT_STANDBY     7

`define PDC_BIT_I2C         6
`define PDC_BIT_SERIAL      5
`define PDC_BIT_ADC         4
`define PDC_BIT_WDT         3
`define PDC_BIT_ITMR        1
`define PDC_BIT_RTC         0
`define PDC_MSTBY_MASK      8'h7b

`define PDC_TC_DIV1         6'h00
`define PDC_TC_DIV8         6'h07
`define PDC_TC_DIV16        6'h0f
`define PDC_TC_DIV32        6'h1f
`define PDC_TC_DIV64        6'h3f
`define PDC_TC_SUB8         3'h7
`define PDC_TC_SUB4         3'h3
`define PDC_TC_SUB2         3'h1

`endif

// ### pdc_pkg.sv
// Types of the power-down and clock-divider control block
package pdc_pkg;

    typedef enum logic [2:0] {
        PDC_ACTIVE   = 3'h0,
        PDC_SLEEP    = 3'h1,
        PDC_SUBACT   = 3'h2,
        PDC_SUBSLEEP = 3'h3,
        PDC_STANDBY  = 3'h4
    } pdc_mode_t;

    typedef enum logic [2:0] {
        PDC_SEL_CTRL_B  = 3'h0,
        PDC_SEL_MSTBY_A = 3'h1,
        PDC_SEL_CTRL_A  = 3'h2,
        PDC_SEL_STATUS  = 3'h3,
        PDC_SEL_NONE    = 3'h4
    } pdc_sel_t;

endpackage : pdc_pkg

// ### pdc_power_ctrl.sv
// Power-down mode and clock-divider control with APB registers
//
// Operation
// - Active divider 0xx undivided, else 8..64
// - New main divider applies only after sleep
// - Sub divider 00 /8, 01 /4, 1x /2
// - New sub divider applies only after sleep
// - Sleep target from four select bits
// - No direct: sleep, subsleep or standby entry
// - Direct set: run-to-run transition, no halt
// - Standby select clear sleeps, set standbys
// - Each module stopped while its bit set
// - Watchdog stop ignored on internal oscillator
// - Reserved standby bits 7, 2 read zero
// - Reset clears all fields and stop bits
`include "pdc_params.svh"

module pdc_power_ctrl (
    input  wire logic                    CLK_SYS,
    input  wire logic                    SYS_RST,
    input  wire logic                    CE,
    input  wire logic                    PSEL,
    input  wire logic                    PENABLE,
    input  wire logic                    PWRITE,
    input  wire logic [`PDC_ADDR_W-1:0]  PADDR,
    input  wire logic [31:0]             PWDATA,
    output logic      [31:0]             PRDATA,
    output logic                         PREADY,
    output logic                         PSLVERR,
    input  wire logic                    SLEEP_EXEC,
    input  wire logic                    WAKE_IRQ,
    input  wire logic                    WATCH_CLK_IN,
    input  wire logic                    WDT_INTOSC_SEL,
    output logic      [2:0]              MODE,
    output logic                         CPU_HALT,
    output logic                         MAIN_CLK_EN,
    output logic                         SUB_CLK_EN,
    output logic                         STOP_I2C,
    output logic                         STOP_SERIAL,
    output logic                         STOP_ADC,
    output logic                         STOP_WDT,
    output logic                         STOP_ITMR,
    output logic                         STOP_RTC
);

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);

    logic [7:0]         ctrl_b_ff;
    logic [7:0]         mstby_ff;
    logic [7:0]         ctrl_a_ff;
    logic [2:0]         act_code_ff;
    logic [1:0]         sub_code_ff;
    logic [31:0]        prdata_ff;
    logic               pready_ff;
    logic               pslverr_ff;
    logic               wdt_stop_ff;
    logic               halt_ff;
    logic [2:0]         watch_sync_ff;
    logic [1:0]         intosc_sync_ff;
    pdc_pkg::pdc_mode_t mode_ff;
    pdc_pkg::pdc_mode_t nxt_mode;
    pdc_pkg::pdc_sel_t  sel;
    logic               setup;
    logic               wr_en;
    logic               running;
    logic               sleep_go;

    pdc_div_if dif ();

    function automatic pdc_pkg::pdc_sel_t reg_decode(input logic [`PDC_ADDR_W-1:0] a);
        case (a)
            `PDC_OFS_CTRL_B:  reg_decode = pdc_pkg::PDC_SEL_CTRL_B;
            `PDC_OFS_MSTBY_A: reg_decode = pdc_pkg::PDC_SEL_MSTBY_A;
            `PDC_OFS_CTRL_A:  reg_decode = pdc_pkg::PDC_SEL_CTRL_A;
            `PDC_OFS_STATUS:  reg_decode = pdc_pkg::PDC_SEL_STATUS;
            default:          reg_decode = pdc_pkg::PDC_SEL_NONE;
        endcase
    endfunction : reg_decode

    assign sel      = reg_decode(PADDR);
    assign setup    = PSEL && !PENABLE;
    assign wr_en    = PSEL && PENABLE && pready_ff && PWRITE && CE;
    assign running  = (mode_ff == pdc_pkg::PDC_ACTIVE) || (mode_ff == pdc_pkg::PDC_SUBACT);
    assign sleep_go = SLEEP_EXEC && running;

    // No wait state: PREADY high in the access cycle right after setup
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else if (CE) begin
            pready_ff  <= setup;
            pslverr_ff <= setup && (sel == pdc_pkg::PDC_SEL_NONE);
        end
    end

    // Read data captured at setup, so it holds through the access
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            prdata_ff <= 32'h0000_0000;
        end else if (CE && setup) begin
            case (sel)
                pdc_pkg::PDC_SEL_CTRL_B:  prdata_ff <= {24'h00_0000, ctrl_b_ff};
                pdc_pkg::PDC_SEL_MSTBY_A: prdata_ff <= {24'h00_0000, mstby_ff};
                pdc_pkg::PDC_SEL_CTRL_A:  prdata_ff <= {24'h00_0000, ctrl_a_ff};
                pdc_pkg::PDC_SEL_STATUS:  prdata_ff <= {24'h00_0000, mode_ff,
                                                        act_code_ff, sub_code_ff};
                default:                  prdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            ctrl_b_ff <= `PDC_RST_CTRL_B;
            mstby_ff  <= `PDC_RST_MSTBY_A;
            ctrl_a_ff <= `PDC_RST_CTRL_A;
        end else if (wr_en) begin
            case (sel)
                pdc_pkg::PDC_SEL_CTRL_B:  ctrl_b_ff <= PWDATA[7:0];
                pdc_pkg::PDC_SEL_MSTBY_A: mstby_ff  <= PWDATA[7:0] & `PDC_MSTBY_MASK;
                pdc_pkg::PDC_SEL_CTRL_A:  ctrl_a_ff <= {PWDATA[`PDC_BIT_STANDBY], 7'h00};
                default:                  ctrl_a_ff <= ctrl_a_ff;
            endcase
        end
    end

    // Pins from outside the clock domain: two flops before use
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            watch_sync_ff  <= 3'h0;
            intosc_sync_ff <= 2'h0;
        end else if (CE) begin
            watch_sync_ff  <= {watch_sync_ff[1:0], WATCH_CLK_IN};
            intosc_sync_ff <= {intosc_sync_ff[0], WDT_INTOSC_SEL};
        end
    end

    // Divider selections are copied only at the sleep instruction
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            act_code_ff <= 3'h0;
            sub_code_ff <= 2'h0;
        end else if (CE && sleep_go) begin
            act_code_ff <= ctrl_b_ff[`PDC_ACT_DIV_HI:`PDC_ACT_DIV_LO];
            sub_code_ff <= ctrl_b_ff[`PDC_SUB_DIV_HI:`PDC_SUB_DIV_LO];
        end
    end

    always_comb begin
        nxt_mode = mode_ff;
        case (mode_ff)
            pdc_pkg::PDC_ACTIVE, pdc_pkg::PDC_SUBACT: begin
                if (SLEEP_EXEC) begin
                    if (ctrl_b_ff[`PDC_BIT_DIRECT]) begin
                        nxt_mode = ctrl_b_ff[`PDC_BIT_LOW_SPEED] ? pdc_pkg::PDC_SUBACT
                                                                : pdc_pkg::PDC_ACTIVE;
                    end else if (ctrl_a_ff[`PDC_BIT_STANDBY]) begin
                        nxt_mode = pdc_pkg::PDC_STANDBY;
                    end else begin
                        nxt_mode = ctrl_b_ff[`PDC_BIT_SUB_SLEEP] ? pdc_pkg::PDC_SUBSLEEP
                                                                : pdc_pkg::PDC_SLEEP;
                    end
                end
            end
            pdc_pkg::PDC_SLEEP, pdc_pkg::PDC_SUBSLEEP: begin
                if (WAKE_IRQ) begin
                    nxt_mode = ctrl_b_ff[`PDC_BIT_LOW_SPEED] ? pdc_pkg::PDC_SUBACT
                                                            : pdc_pkg::PDC_ACTIVE;
                end
            end
            pdc_pkg::PDC_STANDBY: begin
                if (WAKE_IRQ) begin
                    nxt_mode = pdc_pkg::PDC_ACTIVE;
                end
            end
            default: nxt_mode = pdc_pkg::PDC_ACTIVE;
        endcase
    end

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            mode_ff <= pdc_pkg::PDC_ACTIVE;
            halt_ff <= 1'b0;
        end else if (CE) begin
            mode_ff <= nxt_mode;
            halt_ff <= !((nxt_mode == pdc_pkg::PDC_ACTIVE) ||
                         (nxt_mode == pdc_pkg::PDC_SUBACT));
        end
    end

    // Registered so the stop line has no combinational path from the sync chain
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            wdt_stop_ff <= 1'b0;
        end else if (CE) begin
            wdt_stop_ff <= mstby_ff[`PDC_BIT_WDT] && !intosc_sync_ff[1];
        end
    end

    assign dif.act_code   = act_code_ff;
    assign dif.sub_code   = sub_code_ff;
    assign dif.run_main   = (mode_ff == pdc_pkg::PDC_ACTIVE) || (mode_ff == pdc_pkg::PDC_SLEEP);
    assign dif.run_sub    = (mode_ff == pdc_pkg::PDC_SUBACT) ||
                            (mode_ff == pdc_pkg::PDC_SUBSLEEP);
    assign dif.watch_tick = watch_sync_ff[1] && !watch_sync_ff[2];

    pdc_clkdiv u_div (
        .clk (CLK_SYS),
        .rst (SYS_RST),
        .ce  (CE),
        .dif (dif)
    );

    assign PRDATA      = prdata_ff;
    assign PREADY      = pready_ff;
    assign PSLVERR     = pslverr_ff;
    assign MODE        = mode_ff;
    assign CPU_HALT    = halt_ff;
    assign MAIN_CLK_EN = dif.main_tick;
    assign SUB_CLK_EN  = dif.sub_tick;
    assign STOP_I2C    = mstby_ff[`PDC_BIT_I2C];
    assign STOP_SERIAL = mstby_ff[`PDC_BIT_SERIAL];
    assign STOP_ADC    = mstby_ff[`PDC_BIT_ADC];
    assign STOP_WDT    = wdt_stop_ff;
    assign STOP_ITMR   = mstby_ff[`PDC_BIT_ITMR];
    assign STOP_RTC    = mstby_ff[`PDC_BIT_RTC];

    div_hold_a: assert property (
        !(CE && sleep_go) |=> act_code_ff == $past(act_code_ff) && sub_code_ff == $past(sub_code_ff))
        else $error("Applied divider changed without sleep");

    div_apply_a: assert property (
        (CE && sleep_go) |=> act_code_ff == $past(ctrl_b_ff[4:2])
                             && sub_code_ff == $past(ctrl_b_ff[1:0]))
        else $error("Divider not applied at sleep");

    sleep_entry_a: assert property (
        (CE && sleep_go && ctrl_b_ff[7:5] == 3'h0 && !ctrl_a_ff[7])
        |=> mode_ff == pdc_pkg::PDC_SLEEP && CPU_HALT)
        else $error("Sleep mode not entered");

    wake_return_a: assert property (
        (CE && WAKE_IRQ && mode_ff == pdc_pkg::PDC_SUBSLEEP && ctrl_b_ff[6])
        |=> mode_ff == pdc_pkg::PDC_SUBACT && !CPU_HALT)
        else $error("Wake did not return to subactive");

    direct_xfer_a: assert property (
        (CE && sleep_go && ctrl_b_ff[5])
        |=> !CPU_HALT && mode_ff == ($past(ctrl_b_ff[6]) ? pdc_pkg::PDC_SUBACT
                                                         : pdc_pkg::PDC_ACTIVE))
        else $error("Direct transition wrong");

    standby_entry_a: assert property (
        (CE && sleep_go && !ctrl_b_ff[5] && ctrl_a_ff[7]) |=> mode_ff == pdc_pkg::PDC_STANDBY)
        else $error("Standby not entered");

    stop_write_a: assert property (
        (wr_en && sel == pdc_pkg::PDC_SEL_MSTBY_A) |=> STOP_ADC == $past(PWDATA[4])
                                                    && STOP_I2C == $past(PWDATA[6]))
        else $error("Module stop does not follow write");

    reserved_zero_a: assert property (
        (PSEL && PENABLE && PREADY && !PWRITE && $past(sel) == pdc_pkg::PDC_SEL_MSTBY_A)
        |-> PRDATA[7] == 1'b0 && PRDATA[2] == 1'b0)
        else $error("Reserved standby bit read as one");

    wdt_intosc_a: assert property (
        (CE && intosc_sync_ff[1]) |=> !STOP_WDT)
        else $error("Watchdog stopped on internal oscillator");

    // The bench drives CE low once, so the freeze check sees a real stall
    stop_low_a: assert property (
        (wr_en && sel == pdc_pkg::PDC_SEL_MSTBY_A) |=> STOP_SERIAL == $past(PWDATA[5])
            && STOP_ITMR == $past(PWDATA[1]) && STOP_RTC == $past(PWDATA[0]))
        else $error("Module stop low bits do not follow write");

    stop_hold_a: assert property (
        !wr_en |=> $stable(STOP_I2C) && $stable(STOP_SERIAL) && $stable(STOP_ADC)
            && $stable(STOP_ITMR) && $stable(STOP_RTC))
        else $error("Module stop changed without a write");

    wdt_stop_a: assert property (
        (CE && mstby_ff[`PDC_BIT_WDT] && !intosc_sync_ff[1])
        |=> STOP_WDT)
        else $error("Watchdog stop not applied");

    wdt_run_a: assert property (
        (CE && !mstby_ff[`PDC_BIT_WDT])
        |=> !STOP_WDT)
        else $error("Watchdog stopped without its bit");

    subsleep_entry_a: assert property (
        (CE && sleep_go && ctrl_b_ff[7] && !ctrl_b_ff[5] && !ctrl_a_ff[7])
        |=> mode_ff == pdc_pkg::PDC_SUBSLEEP && CPU_HALT)
        else $error("Subsleep mode not entered");

    wake_active_a: assert property (
        (CE && WAKE_IRQ && !ctrl_b_ff[6]
            && (mode_ff == pdc_pkg::PDC_SLEEP || mode_ff == pdc_pkg::PDC_SUBSLEEP))
        |=> mode_ff == pdc_pkg::PDC_ACTIVE && !CPU_HALT)
        else $error("Wake did not return to active");

    standby_wake_a: assert property (
        (CE && WAKE_IRQ && mode_ff == pdc_pkg::PDC_STANDBY)
        |=> mode_ff == pdc_pkg::PDC_ACTIVE && !CPU_HALT)
        else $error("Standby did not wake to active");

    mode_hold_a: assert property (
        (CE && !(running ? SLEEP_EXEC : WAKE_IRQ))
        |=> $stable(mode_ff))
        else $error("Mode changed without an event");

    halt_match_a: assert property (
        CPU_HALT == !running)
        else $error("Halt flag disagrees with mode");

    ce_freeze_a: assert property (
        !CE |=> $stable(mode_ff) && $stable(act_code_ff) && $stable(sub_code_ff)
            && $stable(mstby_ff) && $stable(PREADY))
        else $error("State moved while clock enable low");

    main_off_a: assert property (
        (CE && !dif.run_main)
        |=> !MAIN_CLK_EN)
        else $error("Main rate enable outside main-clock modes");

    sub_off_a: assert property (
        (CE && !dif.run_sub)
        |=> !SUB_CLK_EN)
        else $error("Sub rate enable outside sub-clock modes");

    mstby_rsvd_a: assert property (
        !mstby_ff[7] && !mstby_ff[2])
        else $error("Reserved standby bit set");

    status_read_a: assert property (
        (CE && setup && sel == pdc_pkg::PDC_SEL_STATUS)
        |=> PRDATA[7:0] == {$past(mode_ff), $past(act_code_ff), $past(sub_code_ff)})
        else $error("Status read does not show mode and dividers");

endmodule : pdc_power_ctrl

// ### power_down_clock_control_test.sv
// Self-checking testbench of the power-down and clock-divider control block
module power_down_clock_control_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    logic        ce = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic        sleep_exec = 1'b0;
    logic        wake_irq = 1'b0;
    logic        watch_clk = 1'b0;
    logic        wdt_intosc = 1'b0;
    logic [31:0] prdata;
    logic        pready, pslverr, cpu_halt, main_en, sub_en;
    logic [2:0]  mode;
    logic        s_i2c, s_ser, s_adc, s_wdt, s_itm, s_rtc;
    int          miscompares = 0;
    int          checked = 0;
    int          m_mode = 0;
    int          m_act = 0;
    int          m_sub = 0;

    always #5 clk_sys = ~clk_sys;

    // Watch clock period 16 cycles, phase kept off the system edges
    initial begin
        #3;
        forever #80 watch_clk = ~watch_clk;
    end

    pdc_power_ctrl dut (
        .CLK_SYS(clk_sys), .SYS_RST(sys_rst), .CE(ce), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .SLEEP_EXEC(sleep_exec), .WAKE_IRQ(wake_irq),
        .WATCH_CLK_IN(watch_clk), .WDT_INTOSC_SEL(wdt_intosc), .MODE(mode),
        .CPU_HALT(cpu_halt), .MAIN_CLK_EN(main_en), .SUB_CLK_EN(sub_en),
        .STOP_I2C(s_i2c), .STOP_SERIAL(s_ser), .STOP_ADC(s_adc), .STOP_WDT(s_wdt),
        .STOP_ITMR(s_itm), .STOP_RTC(s_rtc)
    );

    task automatic summarize();
        if (miscompares == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // Holds the request until PREADY is sampled high, then one idle cycle
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1);
        check("pready_wait", n, 32'h1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, a, {24'h0, d}, rd, err);
    endtask : wr

    task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp,
                          input logic eerr);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, a, 32'h0, rd, err);
        check(nm, rd, exp);
        check({nm, "_slverr"}, {31'h0, err}, {31'h0, eerr});
    endtask : rd_chk

    task automatic pulse(input logic wake);
        if (wake) wake_irq <= 1'b1;
        else sleep_exec <= 1'b1;
        @(posedge clk_sys);
        wake_irq   <= 1'b0;
        sleep_exec <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask : pulse

    // Cycles between two enable pulses, after two settling intervals
    task automatic measure(input logic sub, output int iv);
        for (int k = 0; k < 3; k++) begin
            iv = 0;
            do begin
                @(posedge clk_sys);
                iv++;
            end while ((sub ? sub_en : main_en) !== 1'b1 && iv < 3000);
        end
    endtask : measure

    function automatic logic [31:0] status_exp();
        return {24'h0, m_mode[2:0], m_act[2:0], m_sub[1:0]};
    endfunction : status_exp

    initial begin
        #500us;
        miscompares++;
        summarize();
    end

    initial begin
        int          iv;
        int          wake_mode;
        logic [7:0]  v;
        logic [3:0]  k4;
        static int   divs [8] = '{1, 1, 1, 1, 8, 16, 32, 64};
        static int   subs [4] = '{8, 4, 2, 2};
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        void'($urandom(12395));
        rd_chk("ctrl_b_reset", 12'h000, 32'h0, 1'b0);
        rd_chk("mstby_reset", 12'h004, 32'h0, 1'b0);
        rd_chk("ctrl_a_reset", 12'h008, 32'h0, 1'b0);
        rd_chk("status_reset", 12'h00c, 32'h0, 1'b0);
        check("stops_reset", {26'h0, s_i2c, s_ser, s_adc, s_wdt, s_itm, s_rtc}, 32'h0);
        rd_chk("unmapped", 12'h010, 32'h0, 1'b1);
        pulse(1'b1);
        check("wake_in_active", {29'h0, mode}, 32'h0);
        ce <= 1'b0;
        pulse(1'b0);
        check("ce_freeze", {29'h0, mode}, 32'h0);
        check("ce_halt", {31'h0, cpu_halt}, 32'h0);
        ce <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            v = (i == 0) ? 8'hff : 8'($urandom);
            wdt_intosc <= i[0];
            wr(12'h004, v);
            rd_chk("mstby_rd", 12'h004, {24'h0, v & 8'h7b}, 1'b0);
            repeat (4) @(posedge clk_sys);
            check("stops", {27'h0, s_i2c, s_ser, s_adc, s_itm, s_rtc},
                  {27'h0, v[6], v[5], v[4], v[1], v[0]});
            check("stop_wdt", {31'h0, s_wdt}, {31'h0, v[3] & ~i[0]});
        end
        for (int c = 0; c < 8; c++) begin
            wr(12'h000, {3'b001, c[2:0], 2'b00});
            rd_chk("status_before", 12'h00c, status_exp(), 1'b0);
            pulse(1'b0);
            m_act = c;
            m_sub = 0;
            check("direct_active", {29'h0, mode}, 32'h0);
            measure(1'b0, iv);
            check("main_interval", iv, divs[c]);
            rd_chk("status_after", 12'h00c, status_exp(), 1'b0);
        end
        for (int c = 0; c < 4; c++) begin
            wr(12'h000, {6'b011000, c[1:0]});
            pulse(1'b0);
            m_act = 0;
            m_sub = c;
            m_mode = 2;
            check("direct_subact", {29'h0, mode}, 32'h2);
            measure(1'b1, iv);
            check("sub_interval", iv, subs[c] * 16);
            rd_chk("status_sub", 12'h00c, status_exp(), 1'b0);
        end
        wr(12'h000, 8'h20);
        pulse(1'b0);
        m_mode = 0;
        m_sub = 0;
        for (int k = 0; k < 16; k++) begin
            k4 = k[3:0];
            wr(12'h008, {k4[2], 7'h0});
            v = {k4[1], k4[0], k4[3], 3'($urandom), 2'($urandom)};
            wr(12'h000, v);
            rd_chk("status_hold", 12'h00c, status_exp(), 1'b0);
            pulse(1'b0);
            m_act = v[4:2];
            m_sub = v[1:0];
            if (k4[3]) begin
                m_mode = k4[0] ? 2 : 0;
            end else if (k4[2]) begin
                m_mode = 4;
            end else begin
                m_mode = k4[1] ? 3 : 1;
            end
            wake_mode = (k4[2] || !k4[0]) ? 0 : 2;
            check("sleep_target", {29'h0, mode}, m_mode);
            check("cpu_halt", {31'h0, cpu_halt}, {31'h0, !k4[3]});
            rd_chk("status_mode", 12'h00c, status_exp(), 1'b0);
            if (!k4[3]) begin
                pulse(1'b1);
                m_mode = wake_mode;
                check("wake_target", {29'h0, mode}, m_mode);
                check("wake_halt", {31'h0, cpu_halt}, 32'h0);
            end
            if (m_mode == 2) begin
                wr(12'h000, 8'h20);
                pulse(1'b0);
                m_mode = 0;
                m_act = 0;
                m_sub = 0;
                check("back_active", {29'h0, mode}, 32'h0);
            end
        end
        summarize();
    end
endmodule : power_down_clock_control_test
